// ==== inc/lbseq_pkg.sv ====
// constants and types shared by the second led sequencer files
package lbseq_pkg;
  localparam int ADDR_W = 12;
  localparam int REG_IDX_W = ADDR_W - 2;
  // register indices; byte address is four times the index
  localparam logic [7:0] SECOND_LED_LEVEL_RAMP_IDX = 8'h4f;
  localparam logic [7:0] SECOND_LED_PHASE1_TIME_IDX = 8'h50;
  localparam logic [7:0] SECOND_LED_PHASE2_TIME_IDX = 8'h51;
  localparam logic [7:0] SECOND_LED_PHASE3_TIME_IDX = 8'h52;
  localparam logic [7:0] SEQ_STATUS_IDX = 8'h60;
  // field layout
  localparam int RAMP_BIT = 5;
  localparam int LEVEL_W = 4;
  localparam int LEN_W = 7;
  localparam int PHASE_CNT = 3;
  localparam int STAT_UNITS_LSB = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // phase unit timing
  localparam int PHASE_UNIT_MS = 64;
  localparam int CORE_CLK_KHZ = 50000;
  localparam int PHASE_UNIT_CYC = PHASE_UNIT_MS * CORE_CLK_KHZ;
  localparam int TICK_W = 22;
  typedef logic [LEN_W-1:0] lbseq_len_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ONE, PH_TWO, PH_THREE} lbseq_phase_e;
  typedef enum logic [2:0] {
    SEL_LEVEL, SEL_P1, SEL_P2, SEL_P3, SEL_STATUS, SEL_NONE
  } lbseq_sel_e;
endpackage

// ==== inc/lbseq_cfg_if.sv ====
// phase lengths from the registers and sequencer state back to them
`timescale 1ns/1ns
interface lbseq_cfg_if;
  import lbseq_pkg::*;
  lbseq_len_t [PHASE_CNT-1:0] phaseLen;
  lbseq_phase_e phase;
  lbseq_len_t unitsLeft;
  modport regs (output phaseLen, input phase, input unitsLeft);
  modport seq (input phaseLen, output phase, output unitsLeft);
endinterface

// ==== design/lbseq_sequencer.sv ====
// three-phase blink sequencer timed in 64 ms units
`timescale 1ns/1ns
module lbseq_sequencer
  import lbseq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PHASE_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  lbseq_cfg_if.seq cfg
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  lbseq_phase_e phaseQ, phaseD, nextPh;
  lbseq_len_t unitsQ, unitsD;
  logic [TICK_W-1:0] tickQ, tickD;
  wire tickHit = (tickQ == TICK_LAST);

  // first programmed phase after cur, wrapping; idle when none is
  function automatic lbseq_phase_e pickNext(input lbseq_phase_e cur,
      input lbseq_len_t [PHASE_CNT-1:0] lens);
    int k;
    int base;
    logic [1:0] idx;
    pickNext = PH_IDLE;
    base = (cur == PH_IDLE) ? 2 : int'(cur) - 1;
    for (k = 3; k >= 1; k--) begin
      idx = 2'((base + k) % 3);
      if (lens[idx] != '0) begin
        pickNext = lbseq_phase_e'(idx + 2'd1);
      end
    end
  endfunction

  function automatic lbseq_len_t lenOf(input lbseq_phase_e ph,
      input lbseq_len_t [PHASE_CNT-1:0] lens);
    lenOf = '0;
    if (ph != PH_IDLE) begin
      lenOf = lens[2'(ph) - 2'd1];
    end
  endfunction

  assign nextPh = pickNext(phaseQ, cfg.phaseLen);
  // tick restarts on every phase entry so a phase is exactly n units
  assign tickD = (tickHit || phaseQ == PH_IDLE) ? '0 : tickQ + 1'b1;

  always_comb begin
    phaseD = phaseQ;
    unitsD = unitsQ;
    case (phaseQ)
      PH_IDLE: begin
        if (nextPh != PH_IDLE) begin
          phaseD = nextPh;
          unitsD = lenOf(nextPh, cfg.phaseLen);
        end
      end
      default: begin
        if (tickHit) begin
          if (unitsQ <= 7'd1) begin
            phaseD = nextPh;
            unitsD = lenOf(nextPh, cfg.phaseLen);
          end else begin
            unitsD = unitsQ - 7'd1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phaseQ <= PH_IDLE;
      unitsQ <= '0;
      tickQ <= '0;
    end else begin
      phaseQ <= phaseD;
      unitsQ <= unitsD;
      tickQ <= tickD;
    end
  end

  assign cfg.phase = phaseQ;
  assign cfg.unitsLeft = unitsQ;

  sequence endOfPhase;
    tickHit && unitsQ == 7'd1;
  endsequence

  sequence enterPhase(lbseq_phase_e ph);
    (phaseQ != ph) ##1 (phaseQ == ph);
  endsequence

  property loadsLen(lbseq_phase_e ph, int i);
    @(posedge core_clk) disable iff (!nrst)
    enterPhase(ph) |-> unitsQ == $past(cfg.phaseLen[i]);
  endproperty

  chk_phase1_load: assert property (loadsLen(PH_ONE, 0))
    else $error("phase one not loaded with its length");
  chk_phase2_load: assert property (loadsLen(PH_TWO, 1))
    else $error("phase two not loaded with its length");
  chk_phase3_load: assert property (loadsLen(PH_THREE, 2))
    else $error("phase three not loaded with its length");

  chk_step_in_order: assert property (
    @(posedge core_clk) disable iff (!nrst)
    endOfPhase ##0 (phaseQ == PH_ONE && cfg.phaseLen[1] != '0)
      |=> phaseQ == PH_TWO)
    else $error("phase one did not hand over to phase two");
  chk_skip_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    endOfPhase ##0 (phaseQ == PH_ONE && cfg.phaseLen[1] == '0
      && cfg.phaseLen[2] != '0) |=> phaseQ == PH_THREE)
    else $error("zero phase two not skipped");
  chk_unit_hold: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (phaseQ != PH_IDLE && !tickHit) |=> $stable(unitsQ) && $stable(phaseQ))
    else $error("phase count moved without a unit tick");
endmodule

// ==== design/lbseq_top.sv ====
// second led config registers on axi4-lite plus the blink sequencer
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// - control bit 5 enables current ramping
// - control bits 3..0 select sink current level
// - phase one lasts field times 64 ms
// - phase two lasts field times 64 ms
// - phase three lasts field times 64 ms
// - reserved bits are read-only, read zero
// - all four registers clear on reset
module lbseq_top
  import lbseq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PHASE_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic secondLedRampOn,
  output logic [LEVEL_W-1:0] secondLedSinkLevel,
  output logic [1:0] seqPhase
);
  localparam lbseq_sel_e LEN_SEL [PHASE_CNT] = '{SEL_P1, SEL_P2, SEL_P3};

  function automatic lbseq_sel_e decodeSel(input logic [ADDR_W-1:0] a);
    logic [REG_IDX_W-1:0] w;
    w = a[ADDR_W-1:2];
    if (w == REG_IDX_W'(SECOND_LED_LEVEL_RAMP_IDX)) begin
      decodeSel = SEL_LEVEL;
    end else if (w == REG_IDX_W'(SECOND_LED_PHASE1_TIME_IDX)) begin
      decodeSel = SEL_P1;
    end else if (w == REG_IDX_W'(SECOND_LED_PHASE2_TIME_IDX)) begin
      decodeSel = SEL_P2;
    end else if (w == REG_IDX_W'(SECOND_LED_PHASE3_TIME_IDX)) begin
      decodeSel = SEL_P3;
    end else if (w == REG_IDX_W'(SEQ_STATUS_IDX)) begin
      decodeSel = SEL_STATUS;
    end else begin
      decodeSel = SEL_NONE;
    end
  endfunction

  lbseq_cfg_if cfg ();

  logic awreadyQ, wreadyQ, awHaveQ, wHaveQ, awHaveD, wHaveD;
  logic [ADDR_W-1:0] awAddrQ;
  logic [7:0] wDataQ;
  logic wStrbQ;
  logic bvalidQ, bvalidD;
  logic [1:0] brespQ;
  logic arreadyQ, rvalidQ, rvalidD;
  logic [31:0] rdataQ, rdWord;
  logic [1:0] rrespQ;
  logic rampQ;
  logic [LEVEL_W-1:0] levelQ;
  lbseq_len_t [PHASE_CNT-1:0] lenQ;
  logic [PHASE_CNT-1:0] wrLenHit;
  logic touchedQ;
  lbseq_sel_e wrSel, rdSel;

  wire awTake = awvalid & awreadyQ;
  wire wTake = wvalid & wreadyQ;
  // address and data may arrive in either order; write once both held
  wire wrFire = awHaveQ & wHaveQ & ~bvalidQ;
  // only the low byte lane carries register bits
  wire wrByte = wrFire & wStrbQ;
  wire wrLevel = wrByte && wrSel == SEL_LEVEL;
  wire arTake = arvalid & arreadyQ;

  assign wrSel = decodeSel(awAddrQ);
  assign rdSel = decodeSel(araddr);
  assign awHaveD = (awHaveQ | awTake) & ~wrFire;
  assign wHaveD = (wHaveQ | wTake) & ~wrFire;
  assign bvalidD = wrFire | (bvalidQ & ~bready);
  assign rvalidD = arTake | (rvalidQ & ~rready);

  // reserved positions are not stored, so they can only read zero
  assign rdWord = (rdSel == SEL_LEVEL) ?
      {24'h0, 2'b00, rampQ, 1'b0, levelQ} :
    (rdSel == SEL_P1) ? {25'h0, lenQ[0]} :
    (rdSel == SEL_P2) ? {25'h0, lenQ[1]} :
    (rdSel == SEL_P3) ? {25'h0, lenQ[2]} :
    (rdSel == SEL_STATUS) ?
      {17'h0, cfg.unitsLeft, 6'h0, 2'(cfg.phase)} : 32'h0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awreadyQ <= 1'b0;
      wreadyQ <= 1'b0;
      awHaveQ <= 1'b0;
      wHaveQ <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= 1'b0;
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
    end else begin
      awreadyQ <= ~awHaveD & ~bvalidD;
      wreadyQ <= ~wHaveD & ~bvalidD;
      awHaveQ <= awHaveD;
      wHaveQ <= wHaveD;
      if (awTake) begin
        awAddrQ <= awaddr;
      end
      if (wTake) begin
        wDataQ <= wdata[7:0];
        wStrbQ <= wstrb[0];
      end
      bvalidQ <= bvalidD;
      if (wrFire) begin
        brespQ <= (wrSel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arreadyQ <= 1'b0;
      rvalidQ <= 1'b0;
      rdataQ <= '0;
      rrespQ <= RESP_OKAY;
    end else begin
      arreadyQ <= ~rvalidD;
      rvalidQ <= rvalidD;
      if (arTake) begin
        rdataQ <= rdWord;
        rrespQ <= (rdSel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rampQ <= REG_RESET[RAMP_BIT];
      levelQ <= REG_RESET[LEVEL_W-1:0];
    end else if (wrLevel) begin
      rampQ <= wDataQ[RAMP_BIT];
      levelQ <= wDataQ[LEVEL_W-1:0];
    end
  end

  for (genvar g = 0; g < PHASE_CNT; g++) begin : g_len
    assign wrLenHit[g] = wrByte && wrSel == LEN_SEL[g];
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        lenQ[g] <= REG_RESET[LEN_W-1:0];
      end else if (wrLenHit[g]) begin
        lenQ[g] <= wDataQ[LEN_W-1:0];
      end
    end
  end

  // helper for the reset check only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      touchedQ <= 1'b0;
    end else if (wrFire) begin
      touchedQ <= 1'b1;
    end
  end

  assign cfg.phaseLen = lenQ;

  lbseq_sequencer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_seq (
    .core_clk(core_clk),
    .nrst(nrst),
    .cfg(cfg)
  );

  assign awready = awreadyQ;
  assign wready = wreadyQ;
  assign bvalid = bvalidQ;
  assign bresp = brespQ;
  assign arready = arreadyQ;
  assign rvalid = rvalidQ;
  assign rdata = rdataQ;
  assign rresp = rrespQ;
  assign secondLedRampOn = rampQ;
  assign secondLedSinkLevel = levelQ;
  assign seqPhase = 2'(cfg.phase);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_ramp_write: assert property (
    wrLevel |=> secondLedRampOn == $past(wDataQ[RAMP_BIT]))
    else $error("ramp enable did not follow control write");
  chk_level_write: assert property (
    wrLevel |=> secondLedSinkLevel == $past(wDataQ[LEVEL_W-1:0]))
    else $error("sink level did not follow control write");
  chk_reserved_zero: assert property (
    arTake |=> ($past(rdSel) == SEL_STATUS || rdataQ[31:8] == '0)
      && ($past(rdSel) != SEL_LEVEL || (rdataQ[7:6] == '0 && !rdataQ[4]))
      && ($past(rdSel) == SEL_LEVEL || $past(rdSel) == SEL_STATUS
          || !rdataQ[7]))
    else $error("reserved bit read back nonzero");
  chk_reset_zero: assert property (
    !touchedQ |-> !rampQ && levelQ == '0 && lenQ == '0)
    else $error("register not zero after reset");
endmodule

// ==== test/lbseq_led_model.sv ====
// led sink model timing each lit sequencer phase
`timescale 1ns/1ns
module lbseq_led_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] sinkLevel,
  input wire logic [1:0] phaseIn,
  output logic lit,
  output logic [1:0] lastPhase,
  output int lastLen,
  output int changes
);
  logic [1:0] phaseQ;
  int runLen;
  // a zero code sinks no current, so the led stays dark
  assign lit = (phaseIn != 2'h0) && (sinkLevel != 4'h0);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phaseQ <= 2'h0;
      runLen <= 0;
      changes <= 0;
      lastPhase <= 2'h0;
      lastLen <= 0;
    end else if (phaseIn != phaseQ) begin
      lastPhase <= phaseQ;
      lastLen <= runLen;
      changes <= changes + 1;
      runLen <= 1;
      phaseQ <= phaseIn;
    end else begin
      runLen <= runLen + 1;
    end
  end
endmodule

// ==== test/test_lbseq_top.sv ====
// self-checking bench for second led registers and sequencer
`timescale 1ns/1ns
`define CHK(nm, e, s) begin \
  cmpCount++; \
  if ((s) !== (e)) begin \
    badCount++; \
    $display("Error %s expected %h seen %h", nm, e, s); \
  end \
end
module test_lbseq_top;
  import lbseq_pkg::*;
  // short tick keeps phase runs to a few cycles
  localparam int TK = 4;
  localparam logic [ADDR_W-1:0] A0 =
    ADDR_W'({SECOND_LED_LEVEL_RAMP_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] A1 =
    ADDR_W'({SECOND_LED_PHASE1_TIME_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] A2 =
    ADDR_W'({SECOND_LED_PHASE2_TIME_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] A3 =
    ADDR_W'({SECOND_LED_PHASE3_TIME_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] ASTAT = ADDR_W'({SEQ_STATUS_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] ABAD = 12'h200;
  logic [3:0] strb = 4'h1;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ramp, lit;
  logic [1:0] bresp, rresp, phase, lastPhase;
  logic [31:0] rdata;
  logic [3:0] level;
  int lastLen, changes;
  int badCount = 0;
  int cmpCount = 0;
  always #10 core_clk = ~core_clk;
  lbseq_top #(.TICK_CYCLES(TK)) dut_u (.core_clk(core_clk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .secondLedRampOn(ramp), .secondLedSinkLevel(level),
    .seqPhase(phase));
  lbseq_led_model led_u (.core_clk(core_clk), .nrst(nrst), .sinkLevel(level),
    .phaseIn(phase), .lit(lit), .lastPhase(lastPhase), .lastLen(lastLen),
    .changes(changes));
  task automatic results();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // answers taken at the rising edge that completes each handshake
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic ar, wr_, bv;
    logic [1:0] rs;
    int n;
    begin
      n = 0;
      bv = 1'b0;
      rs = 2'h0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bv && n < 50) begin
        @(posedge core_clk);
        ar = awready;
        wr_ = wready;
        bv = bvalid;
        rs = bresp;
        if (ar) awvalid <= 1'b0;
        if (wr_) wvalid <= 1'b0;
        n++;
      end
      bready <= 1'b0;
      if (!bv) badCount++;
      `CHK("bresp", er, rs)
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e,
    input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    begin
      n = 0;
      rv = 1'b0;
      d = '0;
      rs = 2'h0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rv && n < 50) begin
        @(posedge core_clk);
        ar = arready;
        rv = rvalid;
        d = rdata;
        rs = rresp;
        if (ar) arvalid <= 1'b0;
        n++;
      end
      rready <= 1'b0;
      if (!rv) badCount++;
      `CHK("rdata", {24'h0, e}, d)
      `CHK("rresp", er, rs)
    end
  endtask
  task automatic nextPh(output logic [1:0] p, output int len);
    int c0, n;
    begin
      c0 = changes;
      n = 0;
      while (changes == c0 && n < 600) begin
        @(negedge core_clk);
        n++;
      end
      if (changes == c0) badCount++;
      p = lastPhase;
      len = lastLen;
    end
  endtask
  task automatic expPh(input logic [1:0] p, input int len);
    logic [1:0] sp;
    int sl;
    begin
      nextPh(sp, sl);
      `CHK("phase", p, sp)
      `CHK("length", len, sl)
    end
  endtask
  task automatic waitEnd3();
    logic [1:0] sp;
    int sl, k;
    begin
      sp = 2'h0;
      k = 0;
      while (sp !== 2'h3 && k < 6) begin
        nextPh(sp, sl);
        k++;
      end
    end
  endtask
  task automatic allZero();
    rd(A0, 8'h00, RESP_OKAY);
    rd(A1, 8'h00, RESP_OKAY);
    rd(A2, 8'h00, RESP_OKAY);
    rd(A3, 8'h00, RESP_OKAY);
    `CHK("phase", 2'h0, phase)
    `CHK("lit", 1'b0, lit)
    // status is read-only: a write is answered but changes nothing
    wr(ASTAT, 8'h3c, RESP_OKAY);
    rd(ASTAT, 8'h00, RESP_OKAY);
  endtask
  task automatic tCtrl();
    wr(A0, 8'hff, RESP_OKAY);
    rd(A0, 8'h2f, RESP_OKAY);
    `CHK("ramp", 1'b1, ramp)
    `CHK("level", 4'hf, level)
    wr(A0, 8'h16, RESP_OKAY);
    rd(A0, 8'h06, RESP_OKAY);
    `CHK("ramp", 1'b0, ramp)
    `CHK("level", 4'h6, level)
    // low lane strobe off: answered but nothing stored
    strb = 4'h0;
    wr(A0, 8'h21, RESP_OKAY);
    strb = 4'h1;
    rd(A0, 8'h06, RESP_OKAY);
    `CHK("ramp", 1'b0, ramp)
  endtask
  task automatic tLen();
    wr(A1, 8'hff, RESP_OKAY);
    rd(A1, 8'h7f, RESP_OKAY);
    wr(A2, 8'h80, RESP_OKAY);
    rd(A2, 8'h00, RESP_OKAY);
    wr(A3, 8'hff, RESP_OKAY);
    rd(A3, 8'h7f, RESP_OKAY);
    wr(A1, 8'h00, RESP_OKAY);
    wr(A3, 8'h00, RESP_OKAY);
    wr(ABAD, 8'h55, RESP_DECERR);
    rd(ABAD, 8'h00, RESP_DECERR);
  endtask
  task automatic tSeq();
    wr(A1, 8'h01, RESP_OKAY);
    wr(A2, 8'h02, RESP_OKAY);
    wr(A3, 8'h01, RESP_OKAY);
    waitEnd3();
    expPh(2'h1, TK);
    `CHK("lit", 1'b1, lit)
    expPh(2'h2, 2 * TK);
    expPh(2'h3, TK);
    wr(A1, 8'h02, RESP_OKAY);
    wr(A2, 8'h00, RESP_OKAY);
    wr(A3, 8'h03, RESP_OKAY);
    waitEnd3();
    expPh(2'h1, 2 * TK);
    expPh(2'h3, 3 * TK);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    allZero();
    tCtrl();
    tLen();
    tSeq();
    // second reset in mid-run clears everything again
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    allZero();
    results();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    badCount++;
    results();
  end
endmodule
